// [adcsq_pkg.sv]
package adcsq_pkg;

  // ==========================================================
  // Register addresses (low 16 bits of the CPU address)
  localparam logic [15:0] ADDR_RESULT_A_HIGH = 16'hFFE0;
  localparam logic [15:0] ADDR_RESULT_A_LOW  = 16'hFFE1;
  localparam logic [15:0] ADDR_RESULT_B_HIGH = 16'hFFE2;
  localparam logic [15:0] ADDR_RESULT_B_LOW  = 16'hFFE3;
  localparam logic [15:0] ADDR_RESULT_C_HIGH = 16'hFFE4;
  localparam logic [15:0] ADDR_RESULT_C_LOW  = 16'hFFE5;
  localparam logic [15:0] ADDR_RESULT_D_HIGH = 16'hFFE6;
  localparam logic [15:0] ADDR_RESULT_D_LOW  = 16'hFFE7;
  localparam logic [15:0] ADDR_CONV_CTRL     = 16'hFFE8;
  localparam logic [15:0] ADDR_TRIG_CTRL     = 16'hFFE9;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_CONV_CTRL      = 8'h00;
  localparam logic [15:0] RST_RESULT         = 16'h0000;
  localparam logic [7:0]  TRIG_RESERVED_ONES = 8'h7F;
  localparam logic        RST_TRIG_ENABLE    = 1'b0;

  // ==========================================================
  // Control/status field positions
  localparam int POS_END_FLAG   = 7;
  localparam int POS_IRQ_ENABLE = 6;
  localparam int POS_GO         = 5;
  localparam int POS_SCAN       = 4;
  localparam int POS_SPEED      = 3;
  localparam int POS_GROUP      = 2;
  localparam int POS_TRIG_EN    = 7;

  // ==========================================================
  // Conversion lengths in states (one state is one clock)
  localparam logic [8:0] STATES_SLOW_FIRST = 9'h10A; // 266
  localparam logic [8:0] STATES_FAST_FIRST = 9'h086; // 134
  localparam logic [8:0] STATES_SLOW_NEXT  = 9'h100; // 256
  localparam logic [8:0] STATES_FAST_NEXT  = 9'h080; // 128

  // Control register viewed as fields
  typedef struct packed {
    logic       end_flag;
    logic       irq_enable;
    logic       go;
    logic       scan;
    logic       speed;
    logic       group;
    logic [1:0] index;
  } adcsq_ctrl_type;

  // Request to the analog core
  typedef struct packed {
    logic       start;
    logic [2:0] input_sel;
    logic [8:0] states;
  } adcsq_core_req_type;

endpackage

// [adcsq_core.sv]
`timescale 1ns/1ps
module adcsq_core
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         abort,
  // Request
  input  wire adcsq_pkg::adcsq_core_req_type req,
  // Sampled digital value of each analog input
  input  wire logic [79:0]                  sample_in,
  // Answer
  output logic                              done,
  output logic [9:0]                        result,
  output logic [2:0]                        done_input
);

  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic       busy_reg;
  logic [2:0] sel_reg;
  logic [9:0] pick;
  logic       last;

  // ==========================================================
  // Countdown of the conversion states
  assign last       = busy_reg && (count_reg == 9'h001);
  assign count_next = req.start ? req.states : (count_reg - 9'h001);
  assign pick       = sample_in[sel_reg*10 +: 10];

  // Counter and busy state; abort wins so standby kills a conversion
  always_ff @(posedge clk)
  begin
    if (!rst_n || abort)
    begin
      busy_reg  <= 1'b0;
      count_reg <= 9'h000;
      sel_reg   <= 3'h0;
    end
    else if (req.start)
    begin
      busy_reg  <= 1'b1;
      count_reg <= count_next;
      sel_reg   <= req.input_sel;
    end
    else if (busy_reg)
    begin
      busy_reg  <= !last;
      count_reg <= count_next;
    end
  end

  // Result and done strobe come from flip-flops
  always_ff @(posedge clk)
  begin
    if (!rst_n || abort)
    begin
      done       <= 1'b0;
      result     <= 10'h000;
      done_input <= 3'h0;
    end
    else
    begin
      done <= last && !req.start;
      if (last)
      begin
        result     <= pick;
        done_input <= sel_reg;
      end
    end
  end

endmodule // adcsq_core

// [adcsq_top.sv]
`timescale 1ns/1ps
// What this block does
// - Result left-justified: eight bits high byte, two bits top of low byte, rest zero.
// - Inputs 0/4 go to A, 1/5 to B, 2/6 to C, 3/7 to D.
// - All result registers clear on reset and on standby.
// - Results readable anytime; high byte direct, low byte from a holding latch.
// - Control/status register clears to zero on reset and standby.
// - End flag sets after single conversion, or after a whole scan pass.
// - End flag clears by writing zero after reading it as one, or on reset, standby or halt.
// - Bit 6 enables the end-of-conversion interrupt request from the flag.
// - Go bit stays one while converting; single mode clears it at the end.
// - Scan mode repeats until go is written zero or standby.
// - External trigger pin can set the go bit like software.
// - Bit 4 selects single mode or scan mode.
// - Bit 3 selects conversion of at most 266 or 134 states.
// - Low three bits pick group and input, or scan length.
// - A module halt input stops the converter to save power.
// - High byte read captures low byte into latch for the next low read.
// - Trigger enable bit 7 lets a falling pin edge start conversion.
// - Each scan restart begins at the group's first input.
// - Later scan conversions take 256 or 128 states.
module adcsq_top
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Power control
  input  wire logic        STANDBY,
  input  wire logic        MODULE_HALT,
  // CPU byte bus
  input  wire logic [15:0] CPU_ADDR,
  input  wire logic        CPU_RD,
  input  wire logic        CPU_WR,
  input  wire logic [7:0]  CPU_WDATA,
  output logic [7:0]       CPU_RDATA,
  // Trigger pin and sampled analog inputs
  input  wire logic        EXTERNAL_START_PIN_N,
  input  wire logic [79:0] ANALOG_SAMPLES,
  // Interrupt request
  output logic             END_OF_CONVERSION_IRQ
);

  adcsq_pkg::adcsq_ctrl_type     ctrl_reg;
  adcsq_pkg::adcsq_ctrl_type     ctrl_next;
  adcsq_pkg::adcsq_core_req_type core_req;
  logic [15:0] result_reg [4];
  logic [7:0]  hold_reg;
  logic        trig_en_reg;
  logic        flag_seen_reg;
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic        pin_prev_reg;
  logic        first_conv_reg;
  logic [1:0]  scan_pos_reg;
  logic [1:0]  scan_pos_next;
  logic        core_done;
  logic [9:0]  core_result;
  logic [2:0]  core_input;
  logic        clear_all;
  logic        wr_ctrl;
  logic        wr_trig;
  logic        rd_ctrl;
  logic        rd_high;
  logic        rd_low;
  logic [1:0]  rd_slot;
  logic        pin_fall;
  logic        go_set;
  logic        go_start;
  logic        go_stop;
  logic        pass_end;
  logic        scan_cont;
  logic        flag_clear;
  logic [7:0]  rdata_next;

  typedef enum logic [0:0] {IDLE, RUN} adcsq_state_type;
  adcsq_state_type state_reg;
  adcsq_state_type state_next;

  // Decode of a byte address inside the result window
  function automatic logic in_result(input logic [15:0] a);
    in_result = (a >= adcsq_pkg::ADDR_RESULT_A_HIGH) && (a <= adcsq_pkg::ADDR_RESULT_D_LOW);
  endfunction

  // ==========================================================
  // Bus decode
  assign clear_all = STANDBY || MODULE_HALT;
  assign wr_ctrl   = CPU_WR && (CPU_ADDR == adcsq_pkg::ADDR_CONV_CTRL);
  assign wr_trig   = CPU_WR && (CPU_ADDR == adcsq_pkg::ADDR_TRIG_CTRL);
  assign rd_ctrl   = CPU_RD && (CPU_ADDR == adcsq_pkg::ADDR_CONV_CTRL);
  assign rd_high   = CPU_RD && in_result(CPU_ADDR) && !CPU_ADDR[0];
  assign rd_low    = CPU_RD && in_result(CPU_ADDR) && CPU_ADDR[0];
  assign rd_slot   = CPU_ADDR[2:1];

  // ==========================================================
  // Trigger pin: two-stage sync, then falling-edge detect
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= EXTERNAL_START_PIN_N;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_fall = trig_en_reg && pin_prev_reg && !pin_sync_reg;

  // ==========================================================
  // Go bit control and scan stepping
  // pin sets go
  assign go_set   = pin_fall || (wr_ctrl && CPU_WDATA[adcsq_pkg::POS_GO]);
  // A set from idle or a rising go begins a fresh pass
  assign go_start = go_set && !ctrl_reg.go;
  assign go_stop  = wr_ctrl && !CPU_WDATA[adcsq_pkg::POS_GO] && !pin_fall;
  assign pass_end  = core_done && (!ctrl_reg.scan || (scan_pos_reg == ctrl_reg.index));
  assign scan_cont = core_done && ctrl_reg.scan && ctrl_reg.go && !go_stop;
  assign scan_pos_next = (go_start || pass_end) ? 2'b00 : scan_pos_reg + 2'b01;

  // State machine: idle until go, run while converting
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      IDLE:
        if (go_start)
          state_next = RUN;
      RUN:
        if (go_stop || (core_done && !ctrl_reg.scan))
          state_next = IDLE;
      default:
        state_next = IDLE;
    endcase
  end

  // Core request: first start from go, then chained starts in scan
  // mode and input select
  assign core_req.start     = ((state_reg == IDLE) && go_start) || scan_cont;
  assign core_req.input_sel = {ctrl_next.group,
                               ctrl_next.scan ? (scan_cont ? scan_pos_next : 2'b00)
                                              : ctrl_next.index};
  // speed select, later scan conversions are shorter
  assign core_req.states = scan_cont ?
         (ctrl_reg.speed ? adcsq_pkg::STATES_FAST_NEXT : adcsq_pkg::STATES_SLOW_NEXT) :
         (ctrl_next.speed ? adcsq_pkg::STATES_FAST_FIRST : adcsq_pkg::STATES_SLOW_FIRST);

  // ==========================================================
  // Control/status next value
  // clear needs prior read of one; set wins
  assign flag_clear = wr_ctrl && !CPU_WDATA[adcsq_pkg::POS_END_FLAG] && flag_seen_reg;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
      ctrl_next.irq_enable = CPU_WDATA[adcsq_pkg::POS_IRQ_ENABLE];
      ctrl_next.scan       = CPU_WDATA[adcsq_pkg::POS_SCAN];
      ctrl_next.speed      = CPU_WDATA[adcsq_pkg::POS_SPEED];
      ctrl_next.group      = CPU_WDATA[adcsq_pkg::POS_GROUP];
      ctrl_next.index      = CPU_WDATA[1:0];
      ctrl_next.go         = CPU_WDATA[adcsq_pkg::POS_GO];
    end
    // single mode clears go at end
    if (core_done && !ctrl_reg.scan && !go_set)
      ctrl_next.go = 1'b0;
    if (pin_fall)
      ctrl_next.go = 1'b1;
    if (flag_clear)
      ctrl_next.end_flag = 1'b0;
    // flag on single end or full pass
    if (pass_end)
      ctrl_next.end_flag = 1'b1;
  end

  // control cleared on reset and standby; halt too
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N || clear_all)
    begin
      ctrl_reg      <= adcsq_pkg::RST_CONV_CTRL;
      trig_en_reg   <= adcsq_pkg::RST_TRIG_ENABLE;
      state_reg     <= IDLE;
      scan_pos_reg  <= 2'b00;
      flag_seen_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      state_reg    <= state_next;
      if (wr_trig)
        trig_en_reg <= CPU_WDATA[adcsq_pkg::POS_TRIG_EN];
      if (core_req.start || pass_end)
        scan_pos_reg <= core_req.start ? core_req.input_sel[1:0] : 2'b00;
      // Remember a read of the flag as one until the next write
      if (rd_ctrl && ctrl_reg.end_flag)
        flag_seen_reg <= 1'b1;
      else if (wr_ctrl || !ctrl_next.end_flag)
        flag_seen_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Result registers, one per input pair
  // cleared on reset and standby
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_result
      always_ff @(posedge SYS_CLK)
      begin
        if (!RST_N || clear_all)
          result_reg[i] <= adcsq_pkg::RST_RESULT;
        else if (core_done && (core_input[1:0] == 2'(i)))
          result_reg[i] <= {core_result, 6'h00};
      end
    end
  endgenerate

  // ==========================================================
  // Read path: data from flip-flops, one cycle after the read strobe
  // high byte direct, low byte from latch
  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_high)
      rdata_next = result_reg[rd_slot][15:8];
    else if (rd_low)
      rdata_next = hold_reg;
    else if (rd_ctrl)
      rdata_next = ctrl_reg;
    else if (CPU_RD && (CPU_ADDR == adcsq_pkg::ADDR_TRIG_CTRL))
      rdata_next = {trig_en_reg, adcsq_pkg::TRIG_RESERVED_ONES[6:0]};
  end

  // Holding latch and read data register
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      hold_reg  <= 8'h00;
      CPU_RDATA <= 8'h00;
    end
    else
    begin
      CPU_RDATA <= rdata_next;
      if (rd_high)
        hold_reg <= result_reg[rd_slot][7:0];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      END_OF_CONVERSION_IRQ <= 1'b0;
    else
      END_OF_CONVERSION_IRQ <= ctrl_next.end_flag && ctrl_next.irq_enable && !clear_all;
  end

  // ==========================================================
  // analog core sub-module
  adcsq_core u_core
  (
    .clk        (SYS_CLK),
    .rst_n      (RST_N),
    .abort      (clear_all || go_stop),
    .req        (core_req),
    .sample_in  (ANALOG_SAMPLES),
    .done       (core_done),
    .result     (core_result),
    .done_input (core_input)
  );

endmodule // adcsq_top

// [adcsq_top_asserts.sv]
`timescale 1ns/1ps
// ====================
// Port-level checks of the converter control block
module adcsq_top_asserts
(
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  // Power control
  input wire logic        STANDBY,
  input wire logic        MODULE_HALT,
  // CPU byte bus
  input wire logic [15:0] CPU_ADDR,
  input wire logic        CPU_RD,
  input wire logic [7:0]  CPU_RDATA,
  // Interrupt request
  input wire logic        END_OF_CONVERSION_IRQ
);
  // Address decode of the sampled read strobe
  wire map_hit = CPU_ADDR >= 16'hFFE0 && CPU_ADDR <= 16'hFFE9;
  wire res_rd  = CPU_RD && CPU_ADDR >= 16'hFFE0 && CPU_ADDR <= 16'hFFE7;
  wire ctl_rd  = CPU_RD && CPU_ADDR == 16'hFFE8;
  wire trg_rd  = CPU_RD && CPU_ADDR == 16'hFFE9;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Either power-down input clears all but the low-byte latch, read data and pin sync
  sequence s_off;
    STANDBY || MODULE_HALT;
  endsequence

  property p_rd_idle;
    !CPU_RD |=> CPU_RDATA == 8'h00;
  endproperty
  property p_unmapped;
    CPU_RD && !map_hit |=> CPU_RDATA == 8'h00;
  endproperty
  property p_trg_ones;
    trg_rd |=> CPU_RDATA[6:0] == 7'h7F;
  endproperty
  property p_low_zero;
    res_rd && CPU_ADDR[0] |=> CPU_RDATA[5:0] == 6'h00;
  endproperty
  // Request level must match flag and enable read in the same cycle
  property p_irq_flag;
    ctl_rd |=> (CPU_RDATA[7:6] == 2'b11) == END_OF_CONVERSION_IRQ;
  endproperty
  property p_off_ctrl;
    s_off ##1 ctl_rd |=> CPU_RDATA == 8'h00;
  endproperty
  property p_off_trig;
    s_off ##1 trg_rd |=> CPU_RDATA == 8'h7F;
  endproperty
  property p_off_res;
    s_off ##1 (res_rd && !CPU_ADDR[0]) |=> CPU_RDATA == 8'h00;
  endproperty
  property p_off_irq;
    s_off |=> ##1 !END_OF_CONVERSION_IRQ;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_trg_ones: assert property (p_trg_ones)
    else $error("trigger spare bits not one");
  a_low_zero: assert property (p_low_zero)
    else $error("result low byte spare bits not zero");
  a_irq_flag: assert property (p_irq_flag)
    else $error("interrupt level differs from flag and enable");
  a_off_ctrl: assert property (p_off_ctrl)
    else $error("control not cleared by power down");
  a_off_trig: assert property (p_off_trig)
    else $error("trigger enable not cleared by power down");
  a_off_res: assert property (p_off_res)
    else $error("result not cleared by power down");
  a_off_irq: assert property (p_off_irq)
    else $error("interrupt still raised after power down");
endmodule // adcsq_top_asserts

bind adcsq_top adcsq_top_asserts u_adcsq_top_asserts
(
  .SYS_CLK(SYS_CLK),
  .RST_N(RST_N),
  .STANDBY(STANDBY),
  .MODULE_HALT(MODULE_HALT),
  .CPU_ADDR(CPU_ADDR),
  .CPU_RD(CPU_RD),
  .CPU_RDATA(CPU_RDATA),
  .END_OF_CONVERSION_IRQ(END_OF_CONVERSION_IRQ)
);

// [adcsq_analog_model.sv]
`timescale 1ns/1ps
// ====================
// Analog inputs seen as steady digital levels
module adcsq_analog_model
(
  // Level of each of the eight inputs
  output logic [79:0] samples
);
  genvar gi;
  // distinct level per input so a wrong pairing shows
  for (gi = 0; gi < 8; gi++)
  begin : g_in
    assign samples[10*gi +: 10] = 10'(10'h2C5 ^ (10'h049 * gi));
  end
endmodule // adcsq_analog_model

// [test_adcsq_top.sv]
`timescale 1ns/1ps
module test_adcsq_top;
  // ====================
  // Stimulus and observed signals
  logic        sys_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        standby     = 1'b0;
  logic        module_halt = 1'b0;
  logic [15:0] cpu_addr    = 16'h0000;
  logic        cpu_rd      = 1'b0;
  logic        cpu_wr      = 1'b0;
  logic [7:0]  cpu_wdata   = 8'h00;
  logic        trig_n      = 1'b1;
  logic [7:0]  cpu_rdata;
  logic [79:0] samples;
  logic        irq;
  logic [9:0]  s1;
  int          n_fail      = 0;
  int          num_checks  = 0;
  int          cycles      = 0;

  assign s1 = samples[19:10];

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  adcsq_analog_model u_adcsq_analog_model (.samples(samples));

  adcsq_top u_adcsq_top
  (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .STANDBY(standby), .MODULE_HALT(module_halt),
    .CPU_ADDR(cpu_addr), .CPU_RD(cpu_rd), .CPU_WR(cpu_wr), .CPU_WDATA(cpu_wdata),
    .CPU_RDATA(cpu_rdata), .EXTERNAL_START_PIN_N(trig_n), .ANALOG_SAMPLES(samples),
    .END_OF_CONVERSION_IRQ(irq)
  );

  // ====================
  // Bus tasks and comparison
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
  endtask

  // Read data is registered, so it is looked at half a cycle after the read edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge sys_clk);
    cpu_rd = 1'b0;
    chk($sformatf("read %h", a), 16'(exp), 16'(cpu_rdata));
  endtask

  task automatic wait_irq(input int lo, input int hi);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < hi + 4)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("cycles in range", 16'h0001, 16'(n >= lo && n <= hi));
  endtask

  // High byte first, so the low read returns the freshly latched byte
  task automatic chk_res(input int n);
    logic [9:0]  v;
    logic [15:0] a;
    v = samples[10*n +: 10];
    a = 16'hFFE0 + 16'(2 * (n % 4));
    rd(a, v[9:2]);
    rd(a + 16'h0001, {v[1:0], 6'h00});
  endtask

  task automatic sweep();
    for (int i = 0; i < 10; i++)
      rd(16'hFFE0 + 16'(i), (i == 9) ? 8'h7F : 8'h00);
  endtask

  task automatic power_off(input logic halt);
    @(negedge sys_clk);
    standby = !halt;
    module_halt = halt;
    sweep();
    standby = 1'b0;
    module_halt = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // ====================
  // Test sequence
  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    sweep();
    rd(16'hFFEA, 8'h00);
    wr(16'hFFE0, 8'hFF);
    rd(16'hFFE0, 8'h00);
    wr(16'hFFE8, 8'h80);
    rd(16'hFFE8, 8'h00);
    $display("test registers done");
    wr(16'hFFE8, 8'h61);
    wait_irq(266, 274);
    wr(16'hFFE8, 8'h41);
    rd(16'hFFE8, 8'hC1);
    wr(16'hFFE8, 8'h41);
    rd(16'hFFE8, 8'h41);
    chk("irq", 16'h0000, 16'(irq));
    chk_res(1);
    $display("test single slow done");
    wr(16'hFFE8, 8'h6E);
    wait_irq(134, 142);
    wr(16'hFFE8, 8'h0E);
    rd(16'hFFE8, 8'h8E);
    chk("irq", 16'h0000, 16'(irq));
    wr(16'hFFE8, 8'h0E);
    chk_res(6);
    rd(16'hFFE2, s1[9:2]);
    rd(16'hFFE7, {s1[1:0], 6'h00});
    $display("test single fast done");
    wr(16'hFFE8, 8'h72);
    wait_irq(778, 790);
    rd(16'hFFE8, 8'hF2);
    wr(16'hFFE8, 8'h52);
    rd(16'hFFE8, 8'h52);
    for (int i = 0; i < 3; i++)
      chk_res(i);
    rd(16'hFFE6, 8'h00);
    $display("test scan done");
    wr(16'hFFE9, 8'h80);
    rd(16'hFFE9, 8'hFF);
    wr(16'hFFE8, 8'h44);
    trig_n = 1'b0;
    wait_irq(266, 280);
    trig_n = 1'b1;
    chk_res(4);
    rd(16'hFFE8, 8'hC4);
    wr(16'hFFE8, 8'h44);
    wr(16'hFFE9, 8'h00);
    trig_n = 1'b0;
    repeat (300) @(negedge sys_clk);
    rd(16'hFFE8, 8'h44);
    trig_n = 1'b1;
    $display("test trigger done");
    power_off(1'b0);
    wr(16'hFFE8, 8'h72);
    repeat (300) @(negedge sys_clk);
    power_off(1'b1);
    $display("test power down done");
    print_verdict();
  end
endmodule // test_adcsq_top
